// File: core/cbtr_pkg.sv
package cbtr_pkg;
    localparam int WORD_W = 32;
    localparam int CH_N = 16;
    localparam int CHAN_W = 4;
    localparam int FUNC_W = 4;
    localparam int ADDR_W = 16;
    localparam int TRANS_W = CHAN_W + 1;

    // Phase codes {major-1, minor-1}: four phases of four subphases
    localparam logic [3:0] T1_1 = 4'h0;
    localparam logic [3:0] T1_2 = 4'h1;
    localparam logic [3:0] T1_3 = 4'h2;
    localparam logic [3:0] T1_4 = 4'h3;
    localparam logic [3:0] T2_1 = 4'h4;
    localparam logic [3:0] T2_2 = 4'h5;
    localparam logic [3:0] T2_3 = 4'h6;
    localparam logic [3:0] T2_4 = 4'h7;
    localparam logic [3:0] T3_1 = 4'h8;
    localparam logic [3:0] T3_2 = 4'h9;
    localparam logic [3:0] T3_4 = 4'hb;
    localparam logic [3:0] T4_1 = 4'hc;
    localparam logic [3:0] T4_2 = 4'hd;
    localparam logic [3:0] T4_3 = 4'he;
    localparam logic [3:0] T4_4 = 4'hf;

    // Control word fields
    localparam int BIT_DIR = 17;
    localparam int BIT_MON = 16;
    localparam int CMP_W = 16;

    // Control memory and main memory addresses
    localparam logic [ADDR_W-1:0] RELOAD_LO = 16'h0010;
    localparam logic [ADDR_W-1:0] RELOAD_HI = 16'h0090;
    localparam logic [ADDR_W-1:0] INDEX_LO = 16'h0051;
    localparam logic [ADDR_W-1:0] INDEX_HI = 16'h00d1;
    localparam logic [ADDR_W-1:0] INDEX_FORCE = 16'h0041;
    localparam logic [ADDR_W-1:0] NORM_OUT_BASE = 16'h0040;
    localparam logic [ADDR_W-1:0] NORM_IN_BASE = 16'h0060;
    localparam logic [ADDR_W-1:0] ADDR_ODD = 16'h0001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;

    typedef enum logic [1:0] {SEQ_SCAN, SEQ_IO1, SEQ_IO2} cbtr_seq_t;

    typedef struct packed {
        cbtr_seq_t seq;
        logic [FUNC_W-1:0] func;
        logic [CHAN_W-1:0] chan;
        logic [TRANS_W-1:0] trans1;
        logic [TRANS_W-1:0] trans2;
        logic indexed;
        logic io1_flag;
        logic io2_init;
        logic io2_final;
        logic direction_flag;
        logic buffer_terminate_flag;
        logic reload_request_flag;
        logic resume_flag;
        logic cdm_busy;
        logic [WORD_W-1:0] cur_word;
        logic [WORD_W-1:0] z0;
        logic [WORD_W-1:0] mdr;
        logic mem_block;
        logic amps_route;
        logic [CH_N-1:0] output_ack_register_flag;
        logic [CH_N-1:0] function_monitor_flag;
        logic [CH_N-1:0] function_request_flag;
        logic acknowledge_delay_flag;
        logic terminate_output_flag;
        logic output_mode_flag;
        logic priority_toggle_flag;
        logic [WORD_W-1:0] odd_out;
        logic [WORD_W-1:0] even_out;
        logic [ADDR_W-1:0] cm_addr;
        logic cm_rd;
        logic cm_wr;
        logic [WORD_W-1:0] cm_wdata;
        logic [ADDR_W-1:0] mm_addr;
        logic mm_start;
        logic mm_write;
    } cbtr_state_t;

    function automatic logic [ADDR_W-1:0] cbtr_reload_addr(input logic [CHAN_W-1:0] ch, input logic odd);
        cbtr_reload_addr = ((ch[3] ? RELOAD_HI : RELOAD_LO) + {12'h000, ch[2:0], 1'b0}) | (odd ? ADDR_ODD : ADDR_ZERO);
    endfunction : cbtr_reload_addr

    function automatic logic [ADDR_W-1:0] cbtr_index_addr(input logic [CHAN_W-1:0] ch);
        cbtr_index_addr = ((ch[3] ? INDEX_HI : INDEX_LO) - {12'h000, ch[2:0], 1'b0}) | INDEX_FORCE;
    endfunction : cbtr_index_addr

    function automatic logic [ADDR_W-1:0] cbtr_norm_addr(input logic [TRANS_W-1:0] tr, input logic odd);
        cbtr_norm_addr = ((tr[CHAN_W] ? NORM_IN_BASE : NORM_OUT_BASE) + {11'h000, tr[CHAN_W-1:0], 1'b0})
            | (odd ? ADDR_ODD : ADDR_ZERO);
    endfunction : cbtr_norm_addr
endpackage : cbtr_pkg

// File: core/cbtr_phase.sv
module cbtr_phase import cbtr_pkg::*; (
    input wire logic clk, // 25 MHz clock
    input wire logic resetn, // Asynchronous reset, active low
    output logic [3:0] phase // Current {phase, subphase} code
);
    logic [3:0] phase_reg;
    logic [3:0] phase_next;

    always_comb begin
        phase_next = phase_reg + 4'h1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= T1_1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;
endmodule : cbtr_phase

// File: core/cbtr_seq.sv
// Function
// - At scan 2.1 clear function, channel and first translator before loading.
// - At scan 2.2 set first-sequence flag, load winner, note indexed channel.
// - At scan 4.1 clear second translator and direction flag (increment).
// - At scan 4.2 direction from current word bit 17; copy translator.
// - At scan 4.4 set terminate flag when low 16 address bits differ.
// - At scan 4.4 request reload when low bits match and terminal bit 17 set.
// - At first 1.2 stop odd amplifier routing, clear all acknowledge flags.
// - At first 1.3 clear data, request; set mode, toggle priority, set acknowledge.
// - At first 1.3 set terminate output only if no terminate flag, no reload.
// - At first 1.4 set monitor flag when terminate clear and bit 16 set.
// - At first 1.4 set acknowledge delay when terminate flag set.
// - Indexed single-channel output: clear both output registers 2.3, load 2.4.
// - On termination set final flag 4.2; at 4.4 clear address, block memory data.
// - Second 1.3 clear data, set acknowledge and delay; 1.4 load index.
// - Second 2.1 clear flag, release amplifiers; 2.4 re-enable data; 4.1 clear final.
// - Terminal word bit 17 on termination starts automatic reload, no program action.
// - During reload channel stays active; both words replaced by reload words.
// - Monitor flag still raised on each completion when current word bit 16 set.
// - Each reload current word sets new buffer direction through bit 17.
// - Reload words at octal 20/220 plus twice channel; current word one higher.
// - Reload copies both words into the channel's normal control locations.
// - Index stored at octal 121 or 321 minus twice channel number.
//
// The placing of the registers and the plain strobed port were left to the implementer.
module cbtr_seq import cbtr_pkg::*; #(
    parameter int DATA_W = WORD_W,
    parameter int CHANNELS = CH_N
) (
    input wire logic clk, // 25 MHz clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic pri_valid, // Priority network has a winner
    input wire logic [FUNC_W-1:0] pri_func, // Winner function code
    input wire logic [CHAN_W-1:0] pri_chan, // Winner channel number
    input wire logic pri_input, // Winner is an input transfer
    input wire logic pri_indexed, // Winner uses an externally supplied index
    input wire logic [CH_N-1:0] func_request_set, // One-cycle request pulses per channel
    input wire logic [WORD_W-1:0] store_sel_data, // Store selector word
    output logic [ADDR_W-1:0] cm_addr, // Control memory address
    output logic cm_rd, // Control memory read strobe
    output logic cm_wr, // Control memory write strobe
    output logic [WORD_W-1:0] cm_wdata, // Control memory write data
    input wire logic [WORD_W-1:0] cm_rdata, // Control memory read data, taken in the same cycle that cm_rd is high
    output logic [ADDR_W-1:0] mm_addr, // Main memory address
    output logic mm_start, // Main memory cycle start pulse
    output logic mm_write, // Main memory cycle is a write
    output logic [WORD_W-1:0] mm_wdata, // Main memory write data
    input wire logic [WORD_W-1:0] mm_rdata, // Main memory read data
    output logic odd_amps_route, // Odd channel amplifiers routed to store selector
    output logic [WORD_W-1:0] odd_output_register, // Odd output register
    output logic [WORD_W-1:0] even_output_register, // Even output register
    output logic [CH_N-1:0] output_ack_register_flag, // Acknowledge flags per channel
    output logic [CH_N-1:0] function_monitor_flag, // Monitor flags per channel
    output logic [CH_N-1:0] function_request_flag, // Pending function requests
    output logic acknowledge_delay_flag, // Acknowledge delay
    output logic terminate_output_flag, // Terminate output
    output logic output_mode_flag, // Output mode
    output logic priority_toggle_flag, // Priority alternator
    output logic direction_flag, // Set for decrementing buffer
    output logic buffer_terminate_flag, // Terminate flag
    output logic reload_request_flag, // Continuous reload pending
    output logic reload_busy, // Continuous reload sequence running
    output logic [3:0] phase // Current phase code
);
    // The struct and the ports are sized by the package, so other widths cannot be served
    if (DATA_W != WORD_W || CHANNELS != CH_N) begin : g_bad_width
        $error("cbtr_seq: widths must match the package");
    end

    cbtr_state_t s_reg;
    cbtr_state_t s_next;
    logic [3:0] ph;

    cbtr_phase u_phase (
        .clk(clk),
        .resetn(resetn),
        .phase(ph)
    );

    always_comb begin
        s_next = s_reg;
        s_next.cm_rd = 1'b0;
        s_next.cm_wr = 1'b0;
        s_next.mm_start = 1'b0;
        // Set wins over the clear done later in this pass
        s_next.function_request_flag = s_reg.function_request_flag | func_request_set;

        unique case (s_reg.seq)
            SEQ_SCAN: begin
                if (ph == T2_1) begin
                    s_next.func = '0;
                    s_next.chan = '0;
                    s_next.trans1 = '0;
                    s_next.indexed = 1'b0;
                end
                if (ph == T2_2 && pri_valid) begin
                    s_next.io1_flag = 1'b1;
                    s_next.func = pri_func;
                    s_next.chan = pri_chan;
                    s_next.trans1 = {pri_input, pri_chan};
                    s_next.indexed = pri_indexed;
                    s_next.amps_route = 1'b1;
                end
                if (s_reg.io1_flag) begin
                    unique case (ph)
                        T3_1: begin
                            // Indexed channels take their word address from the store selector
                            s_next.cm_addr = s_reg.indexed ? (store_sel_data[ADDR_W-1:0] | ADDR_ODD)
                                : cbtr_norm_addr(s_reg.trans1, 1'b1);
                            s_next.cm_rd = 1'b1;
                        end
                        T3_2: s_next.z0 = cm_rdata;
                        T3_4: s_next.cur_word = s_reg.z0;
                        T4_1: begin
                            s_next.cm_addr = s_reg.indexed ? (store_sel_data[ADDR_W-1:0] & ~ADDR_ODD)
                                : cbtr_norm_addr(s_reg.trans1, 1'b0);
                            s_next.cm_rd = 1'b1;
                            s_next.trans2 = '0;
                            s_next.direction_flag = 1'b0;
                        end
                        T4_2: begin
                            s_next.z0 = cm_rdata;
                            s_next.direction_flag = s_reg.cur_word[BIT_DIR];
                            s_next.trans2 = s_reg.trans1;
                        end
                        T4_3: begin
                            s_next.buffer_terminate_flag = 1'b0;
                            s_next.resume_flag = 1'b0;
                        end
                        T4_4: begin
                            s_next.buffer_terminate_flag =
                                s_reg.cur_word[CMP_W-1:0] != s_reg.z0[CMP_W-1:0];
                            if (s_reg.cur_word[CMP_W-1:0] == s_reg.z0[CMP_W-1:0] && s_reg.z0[BIT_DIR]) begin
                                s_next.reload_request_flag = 1'b1;
                            end
                            s_next.seq = SEQ_IO1;
                        end
                        default: ;
                    endcase
                end
            end
            SEQ_IO1: begin
                unique case (ph)
                    T1_1: begin
                        s_next.mm_addr = s_reg.cur_word[ADDR_W-1:0];
                        s_next.mm_write = 1'b0;
                        s_next.mm_start = 1'b1;
                    end
                    T1_2: begin
                        s_next.amps_route = 1'b0;
                        s_next.output_ack_register_flag = '0;
                    end
                    T1_3: begin
                        s_next.mdr = '0;
                        s_next.function_request_flag[s_reg.chan] = func_request_set[s_reg.chan];
                        s_next.output_mode_flag = 1'b1;
                        s_next.priority_toggle_flag = ~s_reg.priority_toggle_flag;
                        s_next.output_ack_register_flag[s_reg.chan] = 1'b1;
                        if (!s_reg.buffer_terminate_flag && !s_reg.reload_request_flag) begin
                            s_next.terminate_output_flag = 1'b1;
                        end
                    end
                    T1_4: begin
                        if (!s_reg.mem_block) begin
                            s_next.mdr = mm_rdata;
                        end
                        if (!s_reg.buffer_terminate_flag && s_reg.cur_word[BIT_MON]) begin
                            s_next.function_monitor_flag[s_reg.chan] = 1'b1;
                        end
                        if (s_reg.buffer_terminate_flag) begin
                            s_next.acknowledge_delay_flag = 1'b1;
                        end
                    end
                    T2_2: begin
                        s_next.io2_init = !s_reg.buffer_terminate_flag;
                        s_next.amps_route = !s_reg.buffer_terminate_flag;
                    end
                    T2_3: begin
                        s_next.odd_out = '0;
                        if (s_reg.indexed) begin
                            s_next.even_out = '0;
                        end
                    end
                    T2_4: begin
                        s_next.odd_out = s_reg.mdr;
                        if (s_reg.indexed) begin
                            s_next.even_out = s_reg.mdr;
                        end
                    end
                    T4_1: s_next.io1_flag = 1'b0;
                    T4_2: begin
                        if (s_reg.io2_init) begin
                            s_next.io2_final = 1'b1;
                        end
                    end
                    T4_4: begin
                        if (s_reg.io2_init) begin
                            s_next.mm_addr = '0;
                            s_next.mem_block = 1'b1;
                            s_next.seq = SEQ_IO2;
                        end else begin
                            s_next.seq = SEQ_SCAN;
                        end
                    end
                    default: ;
                endcase
            end
            SEQ_IO2: begin
                unique case (ph)
                    T1_1: begin
                        s_next.mm_addr = cbtr_index_addr(s_reg.trans2[CHAN_W-1:0]);
                        s_next.mm_write = 1'b1;
                        s_next.mm_start = 1'b1;
                    end
                    T1_2: s_next.output_ack_register_flag = '0;
                    T1_3: begin
                        s_next.mdr = '0;
                        s_next.output_ack_register_flag[s_reg.chan] = 1'b1;
                        s_next.acknowledge_delay_flag = 1'b1;
                    end
                    T1_4: s_next.mdr = store_sel_data;
                    T2_1: begin
                        s_next.io2_init = 1'b0;
                        s_next.amps_route = 1'b0;
                    end
                    T2_2: begin
                        // Reload shares control memory with the tail of this pass
                        if (s_reg.reload_request_flag) begin
                            s_next.cdm_busy = 1'b1;
                        end
                    end
                    T2_4: s_next.mem_block = 1'b0;
                    T4_1: s_next.io2_final = 1'b0;
                    T4_4: s_next.seq = SEQ_SCAN;
                    default: ;
                endcase
            end
            default: s_next.seq = SEQ_SCAN;
        endcase

        // Continuous reload: current word first, then terminal word, each read then written back
        if (s_reg.cdm_busy) begin
            unique case (ph)
                T3_1: begin
                    s_next.cm_addr = cbtr_reload_addr(s_reg.trans2[CHAN_W-1:0], 1'b1);
                    s_next.cm_rd = 1'b1;
                    s_next.reload_request_flag = 1'b0;
                end
                T3_2: s_next.z0 = cm_rdata;
                T4_1: begin
                    s_next.cm_addr = cbtr_norm_addr(s_reg.trans2, 1'b1);
                    s_next.cm_wdata = s_reg.z0;
                    s_next.cm_wr = 1'b1;
                end
                T1_1: begin
                    s_next.cm_addr = cbtr_reload_addr(s_reg.trans2[CHAN_W-1:0], 1'b0);
                    s_next.cm_rd = 1'b1;
                end
                T1_2: s_next.z0 = cm_rdata;
                T2_1: begin
                    s_next.cm_addr = cbtr_norm_addr(s_reg.trans2, 1'b0);
                    s_next.cm_wdata = s_reg.z0;
                    s_next.cm_wr = 1'b1;
                    s_next.cdm_busy = 1'b0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cm_addr = s_reg.cm_addr;
    assign cm_rd = s_reg.cm_rd;
    assign cm_wr = s_reg.cm_wr;
    assign cm_wdata = s_reg.cm_wdata;
    assign mm_addr = s_reg.mm_addr;
    assign mm_start = s_reg.mm_start;
    assign mm_write = s_reg.mm_write;
    assign mm_wdata = s_reg.mdr;
    assign odd_amps_route = s_reg.amps_route;
    assign odd_output_register = s_reg.odd_out;
    assign even_output_register = s_reg.even_out;
    assign output_ack_register_flag = s_reg.output_ack_register_flag;
    assign function_monitor_flag = s_reg.function_monitor_flag;
    assign function_request_flag = s_reg.function_request_flag;
    assign acknowledge_delay_flag = s_reg.acknowledge_delay_flag;
    assign terminate_output_flag = s_reg.terminate_output_flag;
    assign output_mode_flag = s_reg.output_mode_flag;
    assign priority_toggle_flag = s_reg.priority_toggle_flag;
    assign direction_flag = s_reg.direction_flag;
    assign buffer_terminate_flag = s_reg.buffer_terminate_flag;
    assign reload_request_flag = s_reg.reload_request_flag;
    assign reload_busy = s_reg.cdm_busy;
    assign phase = ph;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_scan_at(logic [3:0] t);
        s_reg.seq == SEQ_SCAN && ph == t;
    endsequence
    sequence seq_io1_at(logic [3:0] t);
        s_reg.seq == SEQ_IO1 && ph == t;
    endsequence

    a_phase_step: assert property ($past(resetn) |-> ph == 4'($past(ph) + 4'h1)) else $error("phase skipped");
    a_scan_clear: assert property (seq_scan_at(T2_1) |=> s_reg.chan == '0 && s_reg.trans1 == '0)
        else $error("scan load not cleared");
    a_scan_load: assert property (seq_scan_at(T2_2) ##0 pri_valid |=> s_reg.io1_flag && s_reg.chan == $past(pri_chan))
        else $error("winner not loaded");
    a_dir_default: assert property (seq_scan_at(T4_1) ##0 s_reg.io1_flag |=> !direction_flag
        ##1 direction_flag == s_reg.cur_word[BIT_DIR]) else $error("direction wrong");
    a_term_detect: assert property (seq_scan_at(T4_4) ##0 s_reg.io1_flag |=>
        buffer_terminate_flag == ($past(s_reg.cur_word[CMP_W-1:0]) != $past(s_reg.z0[CMP_W-1:0])))
        else $error("terminate flag wrong");
    a_ack_sequence: assert property (seq_io1_at(T1_1) |=> ##1 output_ack_register_flag == '0
        ##1 output_ack_register_flag == (16'h0001 << s_reg.chan)) else $error("acknowledge wrong");
    a_term_output: assert property (seq_io1_at(T1_3) ##0 (buffer_terminate_flag || reload_request_flag)
        ##0 !terminate_output_flag |=> !terminate_output_flag) else $error("terminate output set");
    a_monitor_set: assert property (seq_io1_at(T1_4) ##0 (!buffer_terminate_flag && s_reg.cur_word[BIT_MON])
        |=> function_monitor_flag[s_reg.chan]) else $error("monitor not set");
    a_out_load: assert property (seq_io1_at(T2_3) ##0 s_reg.indexed |=> odd_output_register == '0
        && even_output_register == '0 ##1 even_output_register == s_reg.mdr) else $error("outputs wrong");
    a_index_addr: assert property (s_reg.seq == SEQ_IO2 && ph == T1_1 |=> mm_start && mm_write
        && mm_addr == cbtr_index_addr(s_reg.trans2[CHAN_W-1:0])) else $error("index address wrong");
    a_reload_fetch: assert property (s_reg.cdm_busy && ph == T3_1 |=> cm_rd
        && cm_addr == cbtr_reload_addr(s_reg.trans2[CHAN_W-1:0], 1'b1) ##4 cm_wr) else $error("reload wrong");
endmodule : cbtr_seq

// File: sim/cbtr_mem_model.sv
module cbtr_mem_model import cbtr_pkg::*; (
    input wire logic clk, // Clock
    input wire logic [ADDR_W-1:0] cm_addr, // Control memory address
    input wire logic cm_rd, // Read strobe
    input wire logic cm_wr, // Write strobe
    input wire logic [WORD_W-1:0] cm_wdata, // Write data
    output logic [WORD_W-1:0] cm_rdata, // Read data
    input wire logic [ADDR_W-1:0] mm_addr, // Main memory address
    input wire logic mm_start, // Cycle start
    output logic [WORD_W-1:0] mm_rdata // Main memory data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem [0:255];
    initial begin
        foreach (mem[j]) mem[j] = 32'h0;
        mm_rdata = 32'h0;
    end
    // Sequencer takes read data at the edge that ends its strobe; scrambled outside that cycle
    assign cm_rdata = cm_rd ? mem[cm_addr[7:0]] : ~mem[cm_addr[7:0]];
    always @(posedge clk) begin
        if (cm_wr) mem[cm_addr[7:0]] <= cm_wdata;
        if (mm_start) mm_rdata <= {16'h5a5a, mm_addr};
    end
endmodule : cbtr_mem_model

// File: sim/cbtr_seq_tb_top.sv
module cbtr_seq_tb_top import cbtr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, pri_valid = 1'b0, pri_input = 1'b0, pri_indexed = 1'b0;
    logic [3:0] pri_func = 4'h0, pri_chan = 4'h0, phase;
    logic [15:0] func_request_set = 16'h0, cm_addr, mm_addr, mmw_addr;
    logic [15:0] output_ack_register_flag, function_monitor_flag, function_request_flag;
    logic [31:0] store_sel_data = 32'h0, cm_wdata, cm_rdata, mm_wdata, mm_rdata;
    logic [31:0] odd_output_register, even_output_register;
    logic cm_rd, cm_wr, mm_start, mm_write, odd_amps_route, acknowledge_delay_flag, terminate_output_flag;
    logic output_mode_flag, priority_toggle_flag, direction_flag, buffer_terminate_flag;
    logic reload_request_flag, reload_busy;
    logic [15:0] wr_addr [$];
    logic [31:0] wr_data [$];
    int fail_count = 0, compares = 0, i;
    always #20 clk = ~clk;
    cbtr_seq i_cbtr_seq (.*);
    cbtr_mem_model i_cbtr_mem_model (.*);
    always @(posedge clk) begin
        if (cm_wr) begin
            wr_addr.push_back(cm_addr);
            wr_data.push_back(cm_wdata);
        end
        if (mm_start && mm_write) mmw_addr <= mm_addr;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic hang(input int n);
        if (i >= n) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : hang
    // Winner is presented through the whole T2.2 cycle, then withdrawn
    task automatic run(input logic [3:0] ch, input logic idx);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wr_addr.delete();
        wr_data.delete();
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (phase === 4'h4) break;
        end
        hang(40);
        @(posedge clk);
        {pri_valid, pri_chan, pri_func, pri_indexed} <= {1'b1, ch, 4'h1, idx};
        func_request_set <= 16'h0001 << ch;
        @(posedge clk);
        {pri_valid, func_request_set} <= 17'h0;
        for (i = 0; i < 60 && output_ack_register_flag !== 16'h0001 << ch; i++) @(negedge clk);
        hang(60);
        repeat (6) @(negedge clk);
    endtask : run
    task automatic scen_live();
        logic [3:0] p;
        i_cbtr_mem_model.mem[8'h47] = 32'h0003_1000;
        i_cbtr_mem_model.mem[8'h46] = 32'h0000_2000;
        run(4'h3, 1'b0);
        for (i = 0; i < 16; i++) begin
            p = phase;
            @(negedge clk);
            chk(phase, 4'(p + 4'h1));
        end
        chk({direction_flag, buffer_terminate_flag, reload_request_flag}, 3'b110);
        chk({terminate_output_flag, acknowledge_delay_flag}, 2'b01);
        chk({output_mode_flag, priority_toggle_flag, function_request_flag}, 18'h30000);
        chk(function_monitor_flag, 16'h0);
    endtask : scen_live
    task automatic scen_term(input logic rl);
        store_sel_data <= 32'h0000_0044;
        i_cbtr_mem_model.mem[8'h45] = 32'h0001_0100;
        i_cbtr_mem_model.mem[8'h44] = {14'h0, rl, 17'h0100};
        i_cbtr_mem_model.mem[8'h15] = 32'h0002_0300;
        i_cbtr_mem_model.mem[8'h14] = 32'h0000_0400;
        run(4'h2, 1'b1);
        chk({buffer_terminate_flag, reload_request_flag, terminate_output_flag}, {1'b0, rl, ~rl});
        chk(function_monitor_flag, 16'h0004);
        chk({odd_output_register, even_output_register}, {2{32'h5a5a_0100}});
        // Wait for the index store pass, and with reload for both write-backs
        for (i = 0; i < 200 && (rl ? wr_addr.size() < 2 : acknowledge_delay_flag !== 1'b1); i++) @(negedge clk);
        hang(200);
        chk(mmw_addr, 16'h004d);
        chk(acknowledge_delay_flag, 1'b1);
        if (rl) begin
            chk({wr_addr[0], wr_data[0]}, 48'h0045_0002_0300);
            chk({wr_addr[1], wr_data[1]}, 48'h0044_0000_0400);
        end
    endtask : scen_term
    initial begin
        scen_live();
        scen_term(1'b1);
        scen_term(1'b0);
        tally_and_finish();
    end
endmodule : cbtr_seq_tb_top
